/* dv/erb_ram_top_tb.sv */
// erb_ram_top_tb: medium block driven through both user ports and the register port
// assumes the partner models issue the requests and return at the capture edge
`default_nettype none

module erb_ram_top_tb
  import erb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [ERB_WMAX-1:0] W0 = 144'hc_3a5f_0e1d;
  localparam logic [ERB_WMAX-1:0] W1 = 144'h3_c5a0_f1e2;

  logic                clk;
  logic                reset     = 1'b1;
  logic                clr       = 1'b0;
  logic [ERB_RA_W-1:0] reg_addr  = 8'h00;
  logic [ERB_RD_W-1:0] reg_wdata = 32'h0;
  logic                reg_wr    = 1'b0;
  logic                reg_rd    = 1'b0;
  logic [ERB_RD_W-1:0] reg_rdata;
  erb_req_t            a_req;
  erb_req_t            b_req;
  logic [ERB_WMAX-1:0] a_q;
  logic [ERB_WMAX-1:0] b_q;
  logic [ERB_WMAX-1:0] cur;
  logic [ERB_WMAX-1:0] wide;
  int                  num_errors   = 0;
  int                  total_checks = 0;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  erb_ram_top #(.SIZE(ERB_MEDIUM)) uut (
    .CLK(clk), .RESET(reset), .CLR(clr), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .A_REQ(a_req),
    .B_REQ(b_req), .A_Q(a_q), .B_Q(b_q)
  );
  erb_user_model pa (.clk(clk), .req(a_req));
  erb_user_model pb (.clk(clk), .req(b_req));

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [ERB_RD_W-1:0] got, input logic [ERB_RD_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_q(input logic [ERB_WMAX-1:0] got, input logic [ERB_WMAX-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t q got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [ERB_RA_W-1:0] a, input logic [ERB_RD_W-1:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [ERB_RA_W-1:0] a, input logic [ERB_RD_W-1:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 chk_reg(reg_rdata, exp);
  endtask

  // registered read on port b
  task automatic b_read(input logic [ERB_AMAX-1:0] a, input logic [ERB_WMAX-1:0] exp);
    pb.rd(a);
    @(posedge clk);
    #1 chk_q(b_q, exp);
  endtask

  // both ports write, then both read
  task automatic dual(input logic [ERB_AMAX-1:0] wa, wb, ra, rb,
                      input logic [ERB_WMAX-1:0] ea, eb);
    fork
      pa.wr(wa, W0, 16'hf);
      pb.wr(wb, W1, 16'hf);
    join
    fork
      pa.rd(ra);
      pb.rd(rb);
    join
    @(posedge clk);
    #1 chk_q(a_q, ea);
    chk_q(b_q, eb);
  endtask

  initial begin
    #50us;
    num_errors++;
    $display("MISMATCH t=%0t run did not end", $time);
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    #1 chk_q(a_q, '0);
    chk_q(b_q, '0);
    reg_read(ERB_REG_CFG, 32'h019);
    reg_read(ERB_REG_STAT, 32'h0);
    reg_read(8'h08, 32'h0);
    pa.wr(14'h5, W0, 16'hf);
    b_read(14'h5, W0);
    pa.wr(14'h5, '0, 16'h5);
    cur = W0 & 144'hf_f803_fe00;
    b_read(14'h5, cur);
    for (int k = 0; k < 2; k++) begin
      reg_write(ERB_REG_CFG, (k == 1) ? 32'h039 : 32'h019);
      wide = (k == 1) ? W0 : W1;
      fork
        pa.wr(14'h5, wide, 16'hf);
        pb.rd(14'h5);
      join
      @(posedge clk);
      #1 chk_q(b_q, (k == 1) ? cur : '0);
      cur = wide;
      b_read(14'h5, cur);
    end
    // both mixed-port hits flagged as collisions, then cleared
    reg_read(ERB_REG_STAT, 32'h2);
    reg_write(ERB_REG_STAT, 32'h2);
    reg_write(ERB_REG_CFG, 32'h049);
    fork
      pb.rd(14'h5);
      begin
        @(posedge clk);
        @(negedge clk);
        #1 chk_q(b_q, cur);
      end
    join
    reg_write(ERB_REG_CFG, 32'h009);
    pb.rd(14'h5);
    #1 chk_q(b_q, cur);
    reg_write(ERB_REG_CFG, 32'h018);
    dual(14'd10, 14'd20, 14'd20, 14'd10, W1, W0);
    reg_write(ERB_REG_CFG, 32'h118);
    wide = '0;
    for (int k = 0; k < 4; k++) begin
      wide[k*9 +: 9] = 9'(9'h1a1 + k * 9'h33);
      pa.wr(14'(12 + k), {135'h0, wide[k*9 +: 9]}, 16'hffff);
    end
    b_read(14'h3, wide);
    pa.rd(14'd14);
    @(posedge clk);
    #1 chk_q(a_q, {135'h0, wide[18 +: 9]});
    // narrow read on port b, ratio 3 clamps to 2
    reg_write(ERB_REG_CFG, 32'h718);
    b_read(14'd14, {135'h0, wide[18 +: 9]});
    reg_write(ERB_REG_CFG, 32'h01a);
    pa.wr(14'h7, W1, 16'hf);
    @(posedge clk);
    #1 chk_q(a_q, W1);
    reg_write(ERB_REG_CFG, 32'h012);
    pa.wr(14'h8, W0, 16'hf);
    #1 chk_q(a_q, W0);
    reg_write(ERB_REG_CFG, 32'h01b);
    pa.wr(14'h7, W0, 16'hf);
    reg_read(ERB_REG_STAT, 32'h1);
    pa.rd(14'h7);
    @(posedge clk);
    #1 chk_q(a_q, W1);
    reg_write(ERB_REG_STAT, 32'h1);
    reg_read(ERB_REG_STAT, 32'h0);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    #1 chk_q(a_q, '0);
    chk_q(b_q, '0);
    reg_write(ERB_REG_CFG, 32'h01c);
    dual(14'd1, 14'd1, 14'd1, 14'd1, W0, W1);
    complete_run();
  end

endmodule // erb_ram_top_tb

`default_nettype wire

/* dv/erb_user_model.sv */
// erb_user_model: fabric user logic driving one port of the ram block
// assumes the block captures the request on every rising clk edge
`default_nettype none

module erb_user_model
  import erb_pkg::*;
(
  input  wire logic     clk,
  output var  erb_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req = '0;

  ////////////////////////////////////////////////////////////////////////////
  // we held low
  // released lines show the inverse so a stale value never passes
  task automatic idle();
    req.we   <= 1'b0;
    req.re   <= 1'b0;
    req.addr <= ~req.addr;
    req.data <= ~req.data;
    req.be   <= ~req.be;
  endtask

  task automatic wr(input logic [ERB_AMAX-1:0] a, input logic [ERB_WMAX-1:0] d,
                    input logic [ERB_BMAX-1:0] b);
    @(posedge clk);
    req.we   <= 1'b1;
    req.re   <= 1'b0;
    req.addr <= a;
    req.data <= d;
    req.be   <= b;
    @(posedge clk);
    idle();
  endtask

  task automatic rd(input logic [ERB_AMAX-1:0] a);
    @(posedge clk);
    req.we   <= 1'b0;
    req.re   <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    idle();
  endtask

endmodule // erb_user_model

`default_nettype wire

/* src/erb_pkg.sv */
// erb_pkg: sizes, modes, register map and lane helpers of the embedded ram block
// assumes one clock domain and a plain register port beside the two user ports
`default_nettype none

package erb_pkg;

  typedef enum logic [1:0] {ERB_SMALL, ERB_MEDIUM, ERB_LARGE} erb_size_t;
  typedef enum logic [2:0] {ERB_TDP, ERB_SDP, ERB_SP, ERB_ROM, ERB_SP2} erb_mode_t;

  // widest organisation of each size, parity positions included
  localparam int ERB_SMALL_W  = 18;
  localparam int ERB_SMALL_D  = 32;
  localparam int ERB_MEDIUM_W = 36;
  localparam int ERB_MEDIUM_D = 128;
  localparam int ERB_LARGE_W  = 144;
  localparam int ERB_LARGE_D  = 4096;
  localparam int ERB_BYTE_W   = 9;
  localparam int ERB_WMAX     = 144;
  localparam int ERB_AMAX     = 14;
  localparam int ERB_BMAX     = 16;

  // register port
  localparam int         ERB_RA_W     = 8;
  localparam int         ERB_RD_W     = 32;
  localparam logic [7:0] ERB_REG_CFG  = 8'h00;
  localparam logic [7:0] ERB_REG_STAT = 8'h04;
  localparam int ERB_CFG_MODE  = 0;
  localparam int ERB_CFG_OREGA = 3;
  localparam int ERB_CFG_OREGB = 4;
  localparam int ERB_CFG_OLD   = 5;
  localparam int ERB_CFG_FLOW  = 6;
  localparam int ERB_CFG_WSA   = 7;
  localparam int ERB_CFG_WSB   = 9;
  localparam int ERB_CFG_BITS  = 11;
  localparam logic [10:0] ERB_CFG_RST  = 11'h019;
  localparam int ERB_ST_REFUSED = 0;
  localparam int ERB_ST_COLL    = 1;
  localparam logic [1:0]  ERB_WS_MAX   = 2'h2;

  typedef struct packed {
    logic                we;
    logic                re;
    logic [ERB_AMAX-1:0] addr;
    logic [ERB_WMAX-1:0] data;
    logic [ERB_BMAX-1:0] be;
  } erb_req_t;

  function automatic int erb_width(erb_size_t s);
    return (s == ERB_SMALL) ? ERB_SMALL_W : (s == ERB_MEDIUM) ? ERB_MEDIUM_W : ERB_LARGE_W;
  endfunction

  function automatic int erb_depth(erb_size_t s);
    return (s == ERB_SMALL) ? ERB_SMALL_D : (s == ERB_MEDIUM) ? ERB_MEDIUM_D : ERB_LARGE_D;
  endfunction

  // bits of a word covered by lane ln at ratio 1 << ws
  function automatic logic [ERB_WMAX-1:0] erb_lane_mask(int w, logic [1:0] ws, logic [1:0] ln);
    logic [ERB_WMAX-1:0] m;
    int lw;
    m  = '0;
    lw = w >> ws;
    for (int i = 0; i < ERB_WMAX; i++) begin
      m[i] = (i < w) && ((i / lw) == int'(ln));
    end
    return m;
  endfunction

  // narrow data repeated across every lane of the word
  function automatic logic [ERB_WMAX-1:0] erb_widen(int w, logic [1:0] ws, logic [ERB_WMAX-1:0] d);
    logic [ERB_WMAX-1:0] r;
    int lw;
    r  = '0;
    lw = w >> ws;
    for (int i = 0; i < ERB_WMAX; i++) begin
      if (i < w) begin
        r[i] = d[i % lw];
      end
    end
    return r;
  endfunction

  // lane ln of a word, right aligned
  function automatic logic [ERB_WMAX-1:0] erb_narrow(int w, logic [1:0] ws, logic [1:0] ln,
                                                      logic [ERB_WMAX-1:0] v);
    logic [ERB_WMAX-1:0] r;
    int lw;
    r  = '0;
    lw = w >> ws;
    for (int i = 0; i < ERB_WMAX; i++) begin
      if (i < lw && (int'(ln) * lw + i) < ERB_WMAX) begin
        r[i] = v[int'(ln) * lw + i];
      end
    end
    return r;
  endfunction

endpackage

`default_nettype wire

/* src/erb_port.sv */
// erb_port: input registers and address decode of one ram block port
// assumes user logic on the same clock; clr and rst are synchronous
`default_nettype none

module erb_port
  import erb_pkg::*;
#(
  parameter erb_size_t SIZE = ERB_MEDIUM,
  parameter int        W    = 36,
  parameter int        DA   = 7
) (
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     clr,
  input  wire erb_req_t req,
  input  wire logic [1:0] ws,
  input  wire logic     flow,
  output logic          we,
  output logic          re,
  output logic [DA-1:0] word,
  output logic [1:0]    lane,
  output logic [1:0]    ws_q,
  output logic [W-1:0]  mask,
  output logic [W-1:0]  wdat
);

  erb_req_t            req_ff;
  erb_req_t            nxt_req;
  logic [1:0]          ws_ff;
  logic [1:0]          nxt_ws;
  logic [ERB_AMAX-1:0] ra_n_ff;
  logic [ERB_AMAX-1:0] nxt_ra_n;
  logic                re_n_ff;
  logic                nxt_re_n;
  logic                clr_in;
  logic [ERB_AMAX-1:0] a_sel;
  logic [ERB_WMAX-1:0] bmask;

  // input clear only on small and medium
  assign clr_in = clr && (SIZE != ERB_LARGE);

  ////////////////////////////////////////////////////////////////////////////
  // inputs always registered
  always_comb begin
    nxt_req = req;
    nxt_ws  = (ws > ERB_WS_MAX) ? ERB_WS_MAX : ws;
    if (rst || clr_in) begin
      nxt_req = '0;
      nxt_ws  = '0;
    end
  end

  always_ff @(posedge clk) begin
    req_ff <= nxt_req;
    ws_ff  <= nxt_ws;
  end

  always_comb begin
    nxt_ra_n = req.addr;
    nxt_re_n = req.re;
    if (rst || clr_in) begin
      nxt_ra_n = '0;
      nxt_re_n = 1'b0;
    end
  end

  always_ff @(negedge clk) begin
    ra_n_ff <= nxt_ra_n;
    re_n_ff <= nxt_re_n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // write side of a flow port is never used, so one address path serves both
  assign a_sel = flow ? ra_n_ff : req_ff.addr;
  assign we    = req_ff.we;
  assign re    = flow ? re_n_ff : req_ff.re;
  assign ws_q  = ws_ff;
  assign word  = DA'(a_sel >> ws_ff);
  assign lane  = a_sel[1:0] & ((2'h1 << ws_ff) - 2'h1);

  // byte enables on medium and large
  always_comb begin
    bmask = '0;
    for (int i = 0; i < W; i++) begin
      bmask[i] = (SIZE == ERB_SMALL) || req_ff.be[i / ERB_BYTE_W];
    end
  end

  // narrow port mapped onto one lane
  assign mask = W'(erb_lane_mask(W, ws_ff, lane) & bmask);
  assign wdat = W'(erb_widen(W, ws_ff, req_ff.data));

endmodule // erb_port

`default_nettype wire

/* src/erb_ram_top.sv */
// erb_ram_top: one embedded ram block of selectable size with two user ports
// assumes user logic on CLK, synchronous RESET and CLR, and a one-cycle register port
//
// The implementer's own choices: the address map and the strobed register port.
`default_nettype none

module erb_ram_top
  import erb_pkg::*;
#(
  parameter erb_size_t           SIZE      = ERB_MEDIUM,
  parameter logic                PRELOAD   = 1'b0,
  parameter logic [ERB_WMAX-1:0] INIT_WORD = '0
) (
  input  wire logic                CLK,
  input  wire logic                RESET,
  input  wire logic                CLR,
  input  wire logic [ERB_RA_W-1:0] REG_ADDR,
  input  wire logic [ERB_RD_W-1:0] REG_WDATA,
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  output logic [ERB_RD_W-1:0]      REG_RDATA,
  input  wire erb_req_t            A_REQ,
  input  wire erb_req_t            B_REQ,
  output logic [ERB_WMAX-1:0]      A_Q,
  output logic [ERB_WMAX-1:0]      B_Q
);

  // geometry per size; widths hold a ninth bit per byte
  localparam int W  = erb_width(SIZE);
  localparam int D  = erb_depth(SIZE);
  localparam int DA = $clog2(D);

  logic [ERB_CFG_BITS-1:0] cfg_ff;
  logic [ERB_CFG_BITS-1:0] nxt_cfg;
  logic [1:0]              stat_ff;
  logic [1:0]              nxt_stat;
  logic [ERB_RD_W-1:0]     rdata_ff;
  logic [ERB_RD_W-1:0]     nxt_rdata;
  erb_mode_t               mode;
  logic                    oreg_a;
  logic                    oreg_b;
  logic                    old_sel;
  logic                    flow;
  logic                    a_we;
  logic                    a_re;
  logic                    b_we;
  logic                    b_re;
  logic [DA-1:0]           a_word;
  logic [DA-1:0]           b_word;
  logic [DA-1:0]           aw;
  logic [DA-1:0]           bw;
  logic [1:0]              a_lane;
  logic [1:0]              b_lane;
  logic [1:0]              a_ws;
  logic [1:0]              b_ws;
  logic [W-1:0]            a_mask;
  logic [W-1:0]            b_mask;
  logic [W-1:0]            a_wdat;
  logic [W-1:0]            b_wdat;
  logic                    a_wen;
  logic                    b_wen;
  logic                    a_ren;
  logic                    b_ren;
  logic                    ev_refused;
  logic                    ev_coll;
  logic [W-1:0]            a_word_out;
  logic [W-1:0]            b_word_out;
  logic [ERB_WMAX-1:0]     qa_now;
  logic [ERB_WMAX-1:0]     qb_now;
  logic [ERB_WMAX-1:0]     qa_ff;
  logic [ERB_WMAX-1:0]     nxt_qa;
  logic [ERB_WMAX-1:0]     qb_ff;
  logic [ERB_WMAX-1:0]     nxt_qb;
  logic [W-1:0]            mem [D];

  ////////////////////////////////////////////////////////////////////////////
  // configuration fields
  assign mode    = erb_mode_t'(cfg_ff[ERB_CFG_MODE +: 3]);
  assign oreg_a  = cfg_ff[ERB_CFG_OREGA];
  // flow-through forces the b output register off
  assign flow    = cfg_ff[ERB_CFG_FLOW] && (mode == ERB_SDP) && (SIZE != ERB_LARGE);
  assign oreg_b  = cfg_ff[ERB_CFG_OREGB] && !flow;
  // the large block never returns old data across ports
  assign old_sel = cfg_ff[ERB_CFG_OLD] && (SIZE != ERB_LARGE);

  erb_port #(
    .SIZE (SIZE),
    .W    (W),
    .DA   (DA)
  ) u_port_a (
    .clk  (CLK),
    .rst  (RESET),
    .clr  (CLR),
    .req  (A_REQ),
    .ws   (cfg_ff[ERB_CFG_WSA +: 2]),
    .flow (1'b0),
    .we   (a_we),
    .re   (a_re),
    .word (a_word),
    .lane (a_lane),
    .ws_q (a_ws),
    .mask (a_mask),
    .wdat (a_wdat)
  );

  erb_port #(
    .SIZE (SIZE),
    .W    (W),
    .DA   (DA)
  ) u_port_b (
    .clk  (CLK),
    .rst  (RESET),
    .clr  (CLR),
    .req  (B_REQ),
    .ws   (cfg_ff[ERB_CFG_WSB +: 2]),
    .flow (flow),
    .we   (b_we),
    .re   (b_re),
    .word (b_word),
    .lane (b_lane),
    .ws_q (b_ws),
    .mask (b_mask),
    .wdat (b_wdat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // port roles per mode; a mode the size lacks falls back to its nearest kin
  always_comb begin
    a_wen = 1'b0;
    b_wen = 1'b0;
    a_ren = a_re;
    b_ren = b_re;
    aw    = a_word;
    bw    = b_word;
    case (mode)
      ERB_TDP: begin
        // both ports free on medium and large
        a_wen = a_we;
        b_wen = a_we ? b_we && (SIZE != ERB_SMALL) : b_we && (SIZE != ERB_SMALL);
        a_ren = a_re && (SIZE != ERB_SMALL);
      end
      ERB_SDP: begin
        // port a writes, port b reads
        a_wen = a_we;
        a_ren = 1'b0;
      end
      ERB_SP: begin
        // write wins a clash, the read is dropped
        a_wen = a_we;
        a_ren = a_re && !a_we;
        b_ren = 1'b0;
      end
      ERB_SP2: begin
        // each memory owns one half of a medium block
        a_wen = a_we;
        b_wen = b_we && (SIZE == ERB_MEDIUM);
        a_ren = a_re && !a_we;
        b_ren = b_re && !b_we && (SIZE == ERB_MEDIUM);
        if (SIZE == ERB_MEDIUM) begin
          aw[DA-1] = 1'b0;
          bw[DA-1] = 1'b1;
        end
      end
      default: begin
        // rom: writes dropped, both ports read
      end
    endcase
  end

  assign ev_refused = (a_we && !a_wen) || (b_we && !b_wen);
  assign ev_coll    = (aw == bw) && ((a_wen && (b_ren || b_wen)) || (b_wen && a_ren));

  ////////////////////////////////////////////////////////////////////////////
  // array; the registered enable is the write strobe, one edge after capture
  always_ff @(posedge CLK) begin
    // preload on small and medium only
    if (RESET && PRELOAD && (SIZE != ERB_LARGE)) begin
      for (int i = 0; i < D; i++) begin
        mem[i] <= INIT_WORD[W-1:0];
      end
    end else begin
      // masked bits keep their old value
      for (int i = 0; i < W; i++) begin
        if (a_wen && a_mask[i]) begin
          mem[aw][i] <= a_wdat[i];
        end
        if (b_wen && b_mask[i]) begin
          mem[bw][i] <= b_wdat[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array side of each port before the output register
  always_comb begin
    a_word_out = mem[aw];
    b_word_out = mem[bw];
    // a writing port sees its own new word
    if (a_wen) begin
      a_word_out = (mem[aw] & ~a_mask) | (a_wdat & a_mask);
    end else if (b_wen && (aw == bw) && !old_sel) begin
      a_word_out = '0;
    end
    if (b_wen) begin
      b_word_out = (mem[bw] & ~b_mask) | (b_wdat & b_mask);
    end else if (a_wen && (aw == bw) && !old_sel) begin
      b_word_out = '0;
    end
  end

  // each port reads at its own ratio
  assign qa_now = erb_narrow(W, a_ws, a_lane, ERB_WMAX'(a_word_out));
  assign qb_now = erb_narrow(W, b_ws, b_lane, ERB_WMAX'(b_word_out));

  ////////////////////////////////////////////////////////////////////////////
  // output registers; clear reaches them on every size
  always_comb begin
    nxt_qa = qa_ff;
    nxt_qb = qb_ff;
    if (a_ren || a_wen) begin
      nxt_qa = qa_now;
    end
    if (b_ren || b_wen) begin
      nxt_qb = qb_now;
    end
    if (RESET || CLR) begin
      nxt_qa = '0;
      nxt_qb = '0;
    end
  end

  always_ff @(posedge CLK) begin
    qa_ff <= nxt_qa;
    qb_ff <= nxt_qb;
  end

  // bypass shows the array path directly
  assign A_Q = oreg_a ? qa_ff : qa_now;
  assign B_Q = oreg_b ? qb_ff : qb_now;

  ////////////////////////////////////////////////////////////////////////////
  // register port: configuration and sticky status, write one to clear
  always_comb begin
    nxt_cfg   = cfg_ff;
    nxt_stat  = stat_ff;
    nxt_rdata = '0;
    if (REG_WR && REG_ADDR == ERB_REG_CFG) begin
      nxt_cfg = REG_WDATA[ERB_CFG_BITS-1:0];
    end else if (REG_WR && REG_ADDR == ERB_REG_STAT) begin
      nxt_stat = stat_ff & ~REG_WDATA[1:0];
    end
    // a new event beats a clear in the same cycle
    nxt_stat[ERB_ST_REFUSED] = nxt_stat[ERB_ST_REFUSED] | ev_refused;
    nxt_stat[ERB_ST_COLL]    = nxt_stat[ERB_ST_COLL] | ev_coll;
    if (REG_RD && REG_ADDR == ERB_REG_CFG) begin
      nxt_rdata = ERB_RD_W'(cfg_ff);
    end else if (REG_RD && REG_ADDR == ERB_REG_STAT) begin
      nxt_rdata = ERB_RD_W'(stat_ff);
    end
    if (RESET) begin
      nxt_cfg   = ERB_CFG_RST;
      nxt_stat  = '0;
      nxt_rdata = '0;
    end
  end

  always_ff @(posedge CLK) begin
    cfg_ff   <= nxt_cfg;
    stat_ff  <= nxt_stat;
    rdata_ff <= nxt_rdata;
  end

  assign REG_RDATA = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks; helpers only feed them
  logic [DA-1:0] aw_h;
  logic [W-1:0]  old_h;
  logic [W-1:0]  am_h;
  logic [W-1:0]  ad_h;

  always_ff @(posedge CLK) begin
    aw_h  <= aw;
    old_h <= mem[aw];
    am_h  <= a_mask;
    ad_h  <= a_wdat;
  end

  property p_strobe_lands;
    @(posedge CLK) disable iff (RESET)
    (a_wen && !(b_wen && bw == aw)) |=> ((mem[aw_h] & am_h) == (ad_h & am_h));
  endproperty
  a_strobe_lands: assert property (p_strobe_lands)
    else $error("port a write did not land in the array");

  property p_inputs_regd;
    @(posedge CLK) disable iff (RESET)
    (!CLR && !$past(RESET)) |=> (a_we == $past(A_REQ.we)) && (b_we == $past(B_REQ.we));
  endproperty
  a_inputs_regd: assert property (p_inputs_regd)
    else $error("write enable not taken one edge after the request");

  property p_byte_kept;
    @(posedge CLK) disable iff (RESET)
    (a_wen && !a_mask[0] && !b_wen) |=> (mem[aw_h][0] == old_h[0]);
  endproperty
  a_byte_kept: assert property (p_byte_kept)
    else $error("masked bit changed on write");

  property p_clear;
    @(posedge CLK) disable iff (RESET)
    CLR |=> (qa_ff == '0) && (qb_ff == '0) && ((SIZE == ERB_LARGE) || (!a_we && !b_we));
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not empty the registers it owns");

  property p_sp_show;
    @(posedge CLK) disable iff (RESET)
    (mode == ERB_SP && a_wen && a_ws == 2'h0 && &a_mask && !CLR) ##1 oreg_a |-> (A_Q == $past(ERB_WMAX'(a_wdat)));
  endproperty
  a_sp_show: assert property (p_sp_show)
    else $error("single-port output does not show the written word");

  property p_sdp_roles;
    @(posedge CLK) disable iff (RESET)
    (mode == ERB_SDP || SIZE == ERB_SMALL) |-> !b_wen;
  endproperty
  a_sdp_roles: assert property (p_sdp_roles)
    else $error("port b wrote without true dual-port support");

  property p_half;
    @(posedge CLK) disable iff (RESET)
    (mode == ERB_SP2 && SIZE == ERB_MEDIUM) |-> (!aw[DA-1] && bw[DA-1]);
  endproperty
  a_half: assert property (p_half)
    else $error("split memory crossed into the other half");

  property p_dontcare;
    @(posedge CLK) disable iff (RESET)
    (mode == ERB_SDP && a_wen && b_ren && aw == bw && !old_sel) |-> (qb_now == '0);
  endproperty
  a_dontcare: assert property (p_dontcare)
    else $error("mixed-port read did not give the don't-care answer");

  property p_flow;
    @(posedge CLK) disable iff (RESET)
    flow |-> (B_Q == qb_now);
  endproperty
  a_flow: assert property (p_flow)
    else $error("flow-through read passed the output register");

  property p_powerup;
    @(posedge CLK) disable iff (RESET)
    $past(RESET) |-> (qa_ff == '0) && (qb_ff == '0) && (REG_RDATA == '0);
  endproperty
  a_powerup: assert property (p_powerup)
    else $error("outputs not cleared after reset");

endmodule // erb_ram_top

`default_nettype wire
